/* design/sar_host.sv */
// sar_host: host end: strobe timing, serial clock divider, word capture and
// buffering of received words.
// assumes the converter answers on the data line; words leave through a
// valid/ready port that may stall.
//
// Functional notes
// - serial clock clocks conversion and shifting
// - strobe fall wakes converter, starts tracking
// - strobe stays low at least 1 us
// - no strobe rise during power-up
// - strobe rise holds, converts, drives data
// - exactly sixteen clocks per conversion, host supplies
// - after sixteenth fall: release, power down
// - powered down until next strobe fall
// - strobe falls at least 10 us apart
// - data changes on clock falling edges
// - four zeros then twelve bits, MSB first
// - result is plain unsigned binary
// - strobe rise presents first leading zero
// - each falling edge presents next bit
// - last bit out edge fifteen, captured sixteen
// - slow clock allows rising-edge capture
// - rising capture may miss first zero
// - serial clock at most 10 MHz
// - receiver: 16-bit words, strobe frame sync
`default_nettype none
module sar_host #(
    parameter int unsigned WORD_W = sar_pkg::FRAME_BITS,
    parameter int unsigned DEPTH  = sar_pkg::FIFO_DEPTH
) (
    input  wire logic              core_clk_in,
    input  wire logic              rst_in,
    sar_link_if.host               link,
    input  wire logic              conv_enable_in,
    output logic                   word_valid_out,
    input  wire logic              word_ready_in,
    output logic [WORD_W-1:0]      word_data_out,
    output logic                   busy_out
);
    import sar_pkg::*;

    typedef enum logic [2:0] {
        H_IDLE, H_WAKE, H_SETUP, H_LOW, H_HIGH, H_SPACE
    } sar_host_st_t;

    localparam logic [7:0]  WAKE_LOAD  = 8'(POWERUP_CYC - 1);
    localparam logic [7:0]  HALF_LOAD  = 8'(SCLK_HALF_CYC - 1);
    localparam logic [11:0] SPACE_LOAD = 12'(SPACING_CYC - 1);
    localparam logic [4:0]  LAST_BIT   = 5'(FRAME_BITS);

    sar_host_st_t      st_q, st_d;
    logic [7:0]        tmr_q, tmr_d;      // phase timer
    logic [11:0]       spc_q, spc_d;      // strobe-fall spacing timer
    logic [4:0]        bits_q, bits_d;
    logic [WORD_W-1:0] sh_q, sh_d;
    logic [WORD_W-1:0] word_q, word_d;
    logic              push_q, push_d;
    logic              strobe_q, strobe_d;
    logic              sclk_q, sclk_d;
    logic              d1_q, d2_q, d3_q, dat_q, dat_d;
    logic              fifo_ready;

    // shift a captured bit in, MSB first
    function automatic logic [WORD_W-1:0] shift_in(input logic [WORD_W-1:0] cur, input logic b);
        shift_in = {cur[WORD_W-2:0], b};
    endfunction : shift_in

    // data line filter: level taken once stages two and three agree
    always_comb begin
        dat_d = (d2_q == d3_q) ? d3_q : dat_q;
    end

    // strobe and clock sequencing; all timing from the core clock divider
    always_comb begin
        st_d     = st_q;
        tmr_d    = tmr_q;
        spc_d    = (spc_q != 12'h000) ? spc_q - 12'h001 : spc_q;
        bits_d   = bits_q;
        sh_d     = sh_q;
        word_d   = word_q;
        push_d   = 1'b0;
        strobe_d = strobe_q;
        sclk_d   = sclk_q;
        case (st_q)
            H_IDLE: begin
                // only start when the buffer can take the word; this is the
                // back-pressure path, so a stalled reader halts conversions
                sclk_d = SCLK_IDLE;
                if (conv_enable_in && fifo_ready) begin
                    strobe_d = 1'b0;
                    tmr_d    = WAKE_LOAD;
                    spc_d    = SPACE_LOAD;
                    bits_d   = '0;
                    st_d     = H_WAKE;
                end
            end
            H_WAKE: begin
                // strobe held low through the whole power-up window
                if (tmr_q == 8'h00) begin
                    strobe_d = 1'b1;
                    tmr_d    = HALF_LOAD;
                    st_d     = H_SETUP;
                end else begin
                    tmr_d = tmr_q - 8'h01;
                end
            end
            H_SETUP, H_HIGH: begin
                // falling edge: take the bit presented by the previous event;
                // capturing on the fall, not the rise, keeps the first zero
                if (tmr_q == 8'h00) begin
                    sclk_d = 1'b0;
                    sh_d   = shift_in(sh_q, dat_q);
                    bits_d = bits_q + 5'h01;
                    tmr_d  = HALF_LOAD;
                    st_d   = H_LOW;
                end else begin
                    tmr_d = tmr_q - 8'h01;
                end
            end
            H_LOW: begin
                if (tmr_q == 8'h00) begin
                    sclk_d = 1'b1;
                    tmr_d  = HALF_LOAD;
                    // sixteen falls supplied: word complete
                    if (bits_q == LAST_BIT) begin
                        word_d = sh_q;
                        push_d = 1'b1;
                        st_d   = H_SPACE;
                    end else begin
                        st_d = H_HIGH;
                    end
                end else begin
                    tmr_d = tmr_q - 8'h01;
                end
            end
            H_SPACE: begin
                // next strobe fall waits out the spacing from the last one
                if (spc_q == 12'h000) begin
                    st_d = H_IDLE;
                end
            end
            default: begin
                st_d     = H_IDLE;
                strobe_d = STROBE_IDLE;
                sclk_d   = SCLK_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_q     <= H_IDLE;
            tmr_q    <= '0;
            spc_q    <= '0;
            bits_q   <= '0;
            sh_q     <= '0;
            word_q   <= '0;
            push_q   <= 1'b0;
            strobe_q <= STROBE_IDLE;
            sclk_q   <= SCLK_IDLE;
            d1_q     <= 1'b0;
            d2_q     <= 1'b0;
            d3_q     <= 1'b0;
            dat_q    <= 1'b0;
        end else begin
            st_q     <= st_d;
            tmr_q    <= tmr_d;
            spc_q    <= spc_d;
            bits_q   <= bits_d;
            sh_q     <= sh_d;
            word_q   <= word_d;
            push_q   <= push_d;
            strobe_q <= strobe_d;
            sclk_q   <= sclk_d;
            d1_q     <= link.serial_result_line;
            d2_q     <= d1_q;
            d3_q     <= d2_q;
            dat_q    <= dat_d;
        end
    end

    // pins straight from flops; the clock is a divided core-clock level
    assign link.strobe_n   = strobe_q;
    assign link.serial_clk = sclk_q;
    assign busy_out        = (st_q != H_IDLE);

    // received words wait here; ready was checked at strobe fall and only
    // one push happens per frame, so push_q always finds room
    sar_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .core_clk_in   (core_clk_in),
        .rst_in        (rst_in),
        .in_valid_in   (push_q),
        .in_ready_out  (fifo_ready),
        .in_data_in    (word_q),
        .out_valid_out (word_valid_out),
        .out_ready_in  (word_ready_in),
        .out_data_out  (word_data_out)
    );
endmodule : sar_host
`default_nettype wire

/* design/sar_pkg.sv */
// sar_pkg: shared constants for the converter readout link (both ends).
// assumes a 200 MHz core clock on both ends.
`default_nettype none
package sar_pkg;
    localparam int unsigned CLK_MHZ      = 200;
    localparam int unsigned FRAME_BITS   = 16;
    localparam int unsigned LEAD_ZEROS   = 4;
    localparam int unsigned RESULT_BITS  = 12;
    localparam int unsigned FIFO_DEPTH   = 32;
    // times in their own units, cycle counts derived from the clock rate
    localparam int unsigned POWERUP_NS   = 1000;
    localparam int unsigned SPACING_NS   = 10000;
    localparam int unsigned SCLK_MAX_KHZ = 10000;
    // least times round up
    localparam int unsigned POWERUP_CYC  = (POWERUP_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned SPACING_CYC  = (SPACING_NS * CLK_MHZ + 999) / 1000;
    // half a serial clock period at the fastest allowed rate, rounded up
    localparam int unsigned SCLK_HALF_CYC =
        (CLK_MHZ * 1000 + 2 * SCLK_MAX_KHZ - 1) / (2 * SCLK_MAX_KHZ);
    // reset and idle levels of the link
    localparam logic        STROBE_IDLE  = 1'b1;
    localparam logic        SCLK_IDLE    = 1'b1;
endpackage : sar_pkg
`default_nettype wire

/* design/sar_link_if.sv */
// sar_link_if: the three-wire link between converter and host.
// assumes the host end drives strobe and clock; the converter end drives data.
`default_nettype none
interface sar_link_if;
    logic strobe_n;            // conversion strobe, active low
    logic serial_clk;          // serial and conversion clock from the host
    logic serial_result_out;   // converter data bit
    logic serial_result_oe;    // converter drives the data line while high
    logic serial_result_line;  // resolved level of the data wire
    // a released line floats up to its pull-up, modelled as a one, so that
    // the host's filter never samples an undriven level
    assign serial_result_line = serial_result_oe ? serial_result_out : 1'b1;
    modport dev (input strobe_n, input serial_clk, output serial_result_out, output serial_result_oe);
    modport host (output strobe_n, output serial_clk, input serial_result_line);
endinterface : sar_link_if
`default_nettype wire

/* design/sar_fifo.sv */
// sar_fifo: word buffer with valid/ready on both sides.
// assumes a single clock; depth is a power of two.
`default_nettype none
module sar_fifo #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 32
) (
    input  wire logic             core_clk_in,
    input  wire logic             rst_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic [WIDTH-1:0]      out_data_out
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wr_q, wr_d, rd_q, rd_d;
    logic             push, pop;

    // extra pointer bit tells full from empty
    assign in_ready_out  = (wr_q[AW-1:0] != rd_q[AW-1:0]) || (wr_q[AW] == rd_q[AW]);
    assign out_valid_out = (wr_q != rd_q);
    assign out_data_out  = mem_q[rd_q[AW-1:0]];
    assign push          = in_valid_in && in_ready_out;
    assign pop           = out_valid_out && out_ready_in;

    // pointer advance
    always_comb begin
        wr_d = push ? wr_q + 1'b1 : wr_q;
        rd_d = pop ? rd_q + 1'b1 : rd_q;
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
        end
    end

    // storage has no reset; nothing reads a slot before it is written
    always_ff @(posedge core_clk_in) begin
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= in_data_in;
        end
    end
endmodule : sar_fifo
`default_nettype wire

/* design/sar_dev.sv */
// sar_dev: converter end: power-up, track/hold sequencing and serial shift-out.
// assumes strobe and serial clock arrive asynchronously from the host pins;
// the converted code is presented digitally on sample_code_in.
`default_nettype none
module sar_dev (
    input  wire logic                            core_clk_in,
    input  wire logic                            rst_in,
    sar_link_if.dev                              link,
    input  wire logic [sar_pkg::RESULT_BITS-1:0] sample_code_in,
    output logic                                 powered_out,
    output logic                                 tracking_out,
    output logic                                 converting_out
);
    import sar_pkg::*;

    typedef enum logic [1:0] {DEV_DOWN, DEV_TRACK, DEV_CONV} sar_dev_st_t;

    sar_dev_st_t           st_q, st_d;
    logic [1:0]            s1_q, s2_q, s3_q, lvl_q, lvl_d;  // bit0 strobe, bit1 clock
    logic [FRAME_BITS-1:0] sh_q, sh_d;
    logic [4:0]            cnt_q, cnt_d;
    logic                  oe_q, oe_d;
    logic                  strobe_fall, strobe_rise, clk_fall;

    // a change counts once the second and third stages agree
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            lvl_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : lvl_q[i];
        end
    end
    assign strobe_fall = lvl_q[0] && !lvl_d[0];
    assign strobe_rise = !lvl_q[0] && lvl_d[0];
    assign clk_fall    = lvl_q[1] && !lvl_d[1];

    // sequencing; a new strobe fall always restarts, even mid-frame
    always_comb begin
        st_d  = st_q;
        sh_d  = sh_q;
        cnt_d = cnt_q;
        oe_d  = oe_q;
        if (strobe_fall) begin
            st_d  = DEV_TRACK;
            oe_d  = 1'b0;
            cnt_d = '0;
        end else begin
            case (st_q)
                DEV_DOWN: begin
                    st_d = DEV_DOWN;
                end
                DEV_TRACK: begin
                    if (strobe_rise) begin
                        st_d  = DEV_CONV;
                        // held code framed behind leading zeros, plain binary
                        sh_d  = {{LEAD_ZEROS{1'b0}}, sample_code_in};
                        oe_d  = 1'b1;
                        cnt_d = '0;
                    end
                end
                DEV_CONV: begin
                    if (clk_fall) begin
                        sh_d  = {sh_q[FRAME_BITS-2:0], 1'b0};
                        cnt_d = cnt_q + 5'h01;
                        // last bit went out on edge fifteen, released on sixteen
                        if (cnt_q == 5'(FRAME_BITS - 1)) begin
                            st_d = DEV_DOWN;
                            oe_d = 1'b0;
                        end
                    end
                end
                default: begin
                    st_d = DEV_DOWN;
                    oe_d = 1'b0;
                end
            endcase
        end
    end

    // idle link levels are the reset values so no false edge appears
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            s1_q  <= 2'h3;
            s2_q  <= 2'h3;
            s3_q  <= 2'h3;
            lvl_q <= 2'h3;
            st_q  <= DEV_DOWN;
            sh_q  <= '0;
            cnt_q <= '0;
            oe_q  <= 1'b0;
        end else begin
            s1_q  <= {link.serial_clk, link.strobe_n};
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            lvl_q <= lvl_d;
            st_q  <= st_d;
            sh_q  <= sh_d;
            cnt_q <= cnt_d;
            oe_q  <= oe_d;
        end
    end

    // data and enable straight from flops
    assign link.serial_result_out = sh_q[FRAME_BITS-1];
    assign link.serial_result_oe  = oe_q;
    assign powered_out            = (st_q != DEV_DOWN);
    assign tracking_out           = (st_q == DEV_TRACK);
    assign converting_out         = (st_q == DEV_CONV);
endmodule : sar_dev
`default_nettype wire

/* sim/sar_link_monitor.sv */
// sar_link_monitor: timing checks on the link between host and converter.
// assumes plain copies of the link signals plus the core clock and reset.
`default_nettype none
module sar_link_monitor import sar_pkg::*; (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic strobe_n,
    input wire logic serial_clk,
    input wire logic serial_result_out,
    input wire logic serial_result_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [4:0]  falls_q;  // clock falls since the strobe went high
    logic [11:0] low_q;    // cycles spent with the strobe low
    logic [11:0] gap_q;    // cycles since the last strobe fall
    logic        sclk_q;
    logic        strobe_q;
    // counters saturate so that long idle spans cannot wrap into false passes
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            falls_q  <= 5'h00;
            low_q    <= 12'h000;
            gap_q    <= 12'hfff;
            sclk_q   <= 1'b1;
            strobe_q <= 1'b1;
        end else begin
            sclk_q   <= serial_clk;
            strobe_q <= strobe_n;
            falls_q  <= !strobe_n ? 5'h00 : falls_q + 5'(sclk_q && !serial_clk && falls_q < 5'd16);
            low_q    <= strobe_n ? 12'h000 : low_q + 12'(low_q != 12'hfff);
            gap_q    <= (strobe_q && !strobe_n) ? 12'h001 : gap_q + 12'(gap_q != 12'hfff);
        end
    end
    default clocking mon_cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    property p_quiet_low; !strobe_n [*8] |-> !serial_result_oe; endproperty
    property p_drive_on_rise; $rose(strobe_n) |-> ##[1:6] serial_result_oe; endproperty
    property p_first_zero; $rose(serial_result_oe) |-> !serial_result_out; endproperty
    property p_shift_on_fall;
        serial_result_oe && $past(serial_result_oe) && $changed(serial_result_out)
            |-> !serial_clk && $past(serial_clk, 6);
    endproperty
    property p_hold_frame; serial_result_oe && strobe_n && falls_q < 5'd16 |=> serial_result_oe; endproperty
    property p_release_16;
        sclk_q && !serial_clk && strobe_n && falls_q == 5'd15 |-> ##[1:6] !serial_result_oe;
    endproperty
    property p_stay_down; !serial_result_oe && strobe_n && falls_q == 5'd16 |=> !serial_result_oe; endproperty
    property p_low_len; $rose(strobe_n) |-> low_q >= 12'(POWERUP_CYC); endproperty
    property p_fall_gap; $fell(strobe_n) |-> gap_q >= 12'(SPACING_CYC); endproperty
    property p_sclk_half; $changed(serial_clk) |=> $stable(serial_clk) [*8]; endproperty
    a_quiet_low: assert property (p_quiet_low) else $error("data driven while strobe low");
    a_drive_on_rise: assert property (p_drive_on_rise) else $error("data not driven after strobe rise");
    a_first_zero: assert property (p_first_zero) else $error("first bit is not zero");
    a_shift_on_fall: assert property (p_shift_on_fall) else $error("data changed off a clock fall");
    a_hold_frame: assert property (p_hold_frame) else $error("data released early");
    a_release_16: assert property (p_release_16) else $error("data kept after last fall");
    a_stay_down: assert property (p_stay_down) else $error("converter woke without strobe");
    a_low_len: assert property (p_low_len) else $error("strobe low too short");
    a_fall_gap: assert property (p_fall_gap) else $error("strobe falls too close");
    a_sclk_half: assert property (p_sclk_half) else $error("serial clock too fast");
    c_frame: cover property ($fell(serial_result_oe) && falls_q == 5'd16);
    c_rise: cover property ($rose(strobe_n));
    c_gap: cover property ($fell(strobe_n) && gap_q != 12'hfff);
endmodule : sar_link_monitor
`default_nettype wire

/* sim/testbench.sv */
// testbench: host and converter joined by the link, plus a bench-driven converter.
// assumes the 200 MHz core clock; the second converter sees a 48 ns link clock.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic        core_clk_in = 1'b0;
    logic        rst_in      = 1'b1;
    logic        conv_enable_in = 1'b0;
    logic        word_ready_in  = 1'b0;
    logic        word_valid_out, busy_out, powered_out, tracking_out, converting_out, p2, t2, c2;
    logic [15:0] word_data_out, w;
    logic [11:0] code_q  = 12'h000;
    logic [11:0] code2_q = 12'h000;
    logic [15:0] exp_q[$];
    int          num_errors  = 0;
    int          check_count = 0;
    bit          rst_done = 1'b0;
    time         t_fall   = 0;
    sar_link_if sar_link_if_inst();
    sar_link_if abuse_link_if_inst();
    sar_dev sar_dev_inst (.core_clk_in(core_clk_in), .rst_in(rst_in), .link(sar_link_if_inst),
        .sample_code_in(code_q), .powered_out(powered_out), .tracking_out(tracking_out),
        .converting_out(converting_out));
    sar_dev abuse_sar_dev_inst (.core_clk_in(core_clk_in), .rst_in(rst_in), .link(abuse_link_if_inst),
        .sample_code_in(code2_q), .powered_out(p2), .tracking_out(t2), .converting_out(c2));
    sar_host sar_host_inst (.core_clk_in(core_clk_in), .rst_in(rst_in), .link(sar_link_if_inst),
        .conv_enable_in(conv_enable_in), .word_valid_out(word_valid_out), .word_ready_in(word_ready_in),
        .word_data_out(word_data_out), .busy_out(busy_out));
    sar_link_monitor sar_link_monitor_inst (.core_clk_in(core_clk_in), .rst_in(rst_in),
        .strobe_n(sar_link_if_inst.strobe_n), .serial_clk(sar_link_if_inst.serial_clk),
        .serial_result_out(sar_link_if_inst.serial_result_out),
        .serial_result_oe(sar_link_if_inst.serial_result_oe));
    // core clock
    always #2.5 core_clk_in = ~core_clk_in;
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic summarize;
        $display("checks %0d, errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : summarize
    task automatic cycles(input int n);
        repeat (n) @(negedge core_clk_in);
    endtask : cycles
    // 48 ns link clock; each bit is taken just before the fall that replaces it
    task automatic clocks(input int n, output logic [15:0] bits);
        bits = 16'h0000;
        repeat (n) begin
            #24;
            bits = {bits[14:0], abuse_link_if_inst.serial_result_line};
            abuse_link_if_inst.serial_clk = 1'b0;
            #24;
            abuse_link_if_inst.serial_clk = 1'b1;
        end
    endtask : clocks
    task automatic strobe(input logic v, input int n);
        abuse_link_if_inst.strobe_n = v;
        cycles(n);
    endtask : strobe
    // strobe spacing on the host link, measured in time
    always @(negedge sar_link_if_inst.strobe_n) begin
        if (rst_done && t_fall > 0) check(16'($time - t_fall >= 10000), 16'h0001);
        t_fall = $time;
    end
    // wire watch: collect the word at each clock fall, then move to the next code
    always @(posedge sar_link_if_inst.strobe_n) begin
        if (rst_done) begin
            exp_q.push_back({4'h0, code_q});
            check(16'($time - t_fall >= 1000), 16'h0001);
            repeat (16) begin
                @(negedge sar_link_if_inst.serial_clk);
                w = {w[14:0], sar_link_if_inst.serial_result_line};
            end
            check(w, {4'h0, code_q});
            check({13'h0, powered_out, tracking_out, converting_out}, 16'h0005);
            cycles(8);
            check({12'h0, sar_link_if_inst.serial_result_oe, powered_out, tracking_out, converting_out},
                  16'h0000);
            code_q = {code_q[10:0], ~code_q[11]}; // walks through 000 and fff
        end
    end
    // hang guard, sized above the fill-and-drain run
    initial begin
        #450000;
        num_errors++;
        $display("Error at %0t: seen %h expected %h", $time, 1'b0, 1'b1);
        summarize();
    end
    initial begin : main
        logic [15:0] b;
        abuse_link_if_inst.strobe_n   = 1'b1;
        abuse_link_if_inst.serial_clk = 1'b1;
        cycles(10);
        rst_in   = 1'b0;
        rst_done = 1'b1;
        check({11'h0, sar_link_if_inst.strobe_n, sar_link_if_inst.serial_clk,
               sar_link_if_inst.serial_result_oe, word_valid_out, busy_out}, 16'h0018);
        clocks(5, b);
        check({14'h0, abuse_link_if_inst.serial_result_oe, p2}, 16'h0000);
        code2_q = 12'hfff;
        strobe(1'b0, 8);
        check({13'h0, p2, t2, c2}, 16'h0006);
        clocks(3, b);
        check(16'(abuse_link_if_inst.serial_result_oe), 16'h0000);
        strobe(1'b0, 200);
        strobe(1'b1, 8);
        check({13'h0, abuse_link_if_inst.serial_result_oe, abuse_link_if_inst.serial_result_line, c2},
              16'h0005);
        clocks(16, b);
        check(b, 16'h0fff);
        cycles(8);
        check({14'h0, abuse_link_if_inst.serial_result_oe, p2}, 16'h0000);
        clocks(4, b);
        check(16'(abuse_link_if_inst.serial_result_oe), 16'h0000);
        strobe(1'b0, 210);
        code2_q = 12'h5a3;
        strobe(1'b1, 8);
        clocks(5, b);
        strobe(1'b0, 8);
        check({14'h0, abuse_link_if_inst.serial_result_oe, t2}, 16'h0001);
        strobe(1'b0, 200);
        strobe(1'b1, 8);
        clocks(16, b);
        check(b, 16'h05a3);
        conv_enable_in = 1'b1;
        cycles(2);
        check({14'h0, busy_out, sar_link_if_inst.strobe_n}, 16'h0002);
        for (int k = 0; k < 80000 && exp_q.size() < 32; k++) cycles(1);
        cycles(3000);
        check(16'(exp_q.size()), 16'd32);
        check({14'h0, busy_out, sar_link_if_inst.strobe_n}, 16'h0001);
        conv_enable_in = 1'b0;
        word_ready_in  = 1'b1;
        repeat (32) begin
            for (int k = 0; k < 5000 && word_valid_out !== 1'b1; k++) cycles(1);
            check(word_data_out, exp_q.pop_front());
            cycles(1);
        end
        word_ready_in = 1'b0;
        cycles(2);
        check({14'h0, word_valid_out, busy_out}, 16'h0000);
        summarize();
    end
endmodule : testbench
`default_nettype wire
